/* File: cit_defs.svh */
/*
  addresses, field positions and sizes for the identifier tag and mask block.
  assumes inclusion by bare name from the package and modules.
*/
`ifndef CIT_DEFS_SVH
`define CIT_DEFS_SVH
`define CIT_ADDR_TAG1 8'hBC
`define CIT_ADDR_TAG2 8'hBD
`define CIT_ADDR_TAG3 8'hBE
`define CIT_ADDR_TAG4 8'hBF
`define CIT_ADDR_MSK1 8'hC4
`define CIT_ADDR_MSK2 8'hC5
`define CIT_ADDR_MSK3 8'hC6
`define CIT_ADDR_MSK4 8'hC7
`define CIT_NUM_OBJ 15
`define CIT_OBJ_W 4
`define CIT_RTR_BIT 2
`define CIT_RB1_BIT 1
`define CIT_RB0_BIT 0
`endif

/* File: cit_pkg.sv */
/*
  types for the identifier tag and mask block.
  assumes cit_defs.svh is on the include path.
*/
package cit_pkg;
  `include "cit_defs.svh"
  typedef struct packed {
    logic [28:0] id;
    logic rtr;
    logic rb1;
    logic rb0;
  } cit_tag_t;
  typedef struct packed {
    logic [28:0] id;
    logic rtr;
    logic extended_format_select;
  } cit_msk_t;
endpackage

/* File: cit_match.sv */
/*
  acceptance compare of one received identifier against one object's tag and mask.
  assumes tag and mask in canonical 29-bit right-aligned form.
*/
module cit_match
  import cit_pkg::*;
(
  input wire logic ext,
  input wire cit_tag_t tag,
  input wire cit_msk_t msk,
  input wire logic [28:0] rx_id,
  input wire logic rx_rtr,
  input wire logic rx_ide,
  output logic hit
);
  logic [28:0] idm;
  always_comb begin
    // standard objects compare only the low eleven bits
    idm = ext ? msk.id : {18'h0_0000, msk.id[10:0]};
    hit = (((rx_id ^ tag.id) & idm) == 29'h0000_0000)
      && (!msk.rtr || (rx_rtr == tag.rtr))
      && (!msk.extended_format_select || (rx_ide == ext));
  end
endmodule

/* File: cit_top.sv */
/*
  per-object identifier tag and mask registers on the special function bus,
  with acceptance filter for reception and unmasked transmit identifier.
  assumes single-cycle sfr access, object index given by the selection logic outside.
*/
// How it works
// - standard: id 10:3 in tag byte1
// - standard: id 2:0 in byte2 bits 7:5
// - standard: tag byte3 wholly reserved
// - standard: byte4 bit2 rtr, bit0 rb0
// - extended: id 28:21 in tag byte1
// - extended: id 20:13 in tag byte2
// - extended: id 12:5 in tag byte3
// - extended: byte4 id 4:0, rtr, rb1, rb0
// - reserved bits read arbitrary
// - tag and mask have no reset value
// - mask one compares, zero forces pass
// - extension setting selects layout
// - mask used only for reception
module cit_top
  import cit_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  output logic SFR_SEL,
  input wire logic [3:0] OBJ_SEL,
  input wire logic [14:0] OBJ_EXT,
  input wire logic [14:0] OBJ_RX_EN,
  input wire logic [3:0] TX_OBJ,
  output logic [28:0] TX_ID,
  output logic TX_RTR,
  output logic TX_RB1,
  output logic TX_RB0,
  input wire logic RX_VALID,
  input wire logic [28:0] RX_ID,
  input wire logic RX_RTR,
  input wire logic RX_IDE,
  output logic [14:0] RX_HIT
);
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [7:0] rdata;
    logic [28:0] tx_id;
    logic tx_rtr;
    logic tx_rb1;
    logic tx_rb0;
    logic [14:0] hit;
  } cit_state_t;

  cit_state_t s_q, s_d;
  // storage arrays carry no reset by design
  cit_tag_t tag_q [0:`CIT_NUM_OBJ-1];
  cit_msk_t msk_q [0:`CIT_NUM_OBJ-1];
  logic [14:0] hit_c;
  logic sel_ok, ext_sel;
  cit_tag_t tsel;
  cit_msk_t msel;

  function automatic logic is_mine(input logic [7:0] a);
    is_mine = (a[7:2] == 6'(`CIT_ADDR_TAG1 >> 2)) || (a[7:2] == 6'(`CIT_ADDR_MSK1 >> 2));
  endfunction

  assign sel_ok = (OBJ_SEL < 4'(`CIT_NUM_OBJ));
  assign ext_sel = sel_ok ? OBJ_EXT[OBJ_SEL] : 1'b0;
  assign tsel = sel_ok ? tag_q[OBJ_SEL] : '0;
  assign msel = sel_ok ? msk_q[OBJ_SEL] : '0;
  assign SFR_SEL = is_mine(SFR_ADDR);

  genvar g;
  generate
    for (g = 0; g < `CIT_NUM_OBJ; g++) begin : g_obj
      logic h;
      cit_match u_match (
        .ext(OBJ_EXT[g]),
        .tag(tag_q[g]),
        .msk(msk_q[g]),
        .rx_id(RX_ID),
        .rx_rtr(RX_RTR),
        .rx_ide(RX_IDE),
        .hit(h)
      );
      assign hit_c[g] = h && OBJ_RX_EN[g] && RX_VALID;
    end
  endgenerate

  // register writes: layout depends on the object's extension setting
  always_ff @(posedge CORE_CLK) begin
    if (SFR_WR && sel_ok && s_q.rst_s2) begin
      case (SFR_ADDR)
        `CIT_ADDR_TAG1: begin
          if (ext_sel) tag_q[OBJ_SEL].id[28:21] <= SFR_WDATA;
          else tag_q[OBJ_SEL].id[10:3] <= SFR_WDATA;
        end
        `CIT_ADDR_TAG2: begin
          if (ext_sel) tag_q[OBJ_SEL].id[20:13] <= SFR_WDATA;
          else tag_q[OBJ_SEL].id[2:0] <= SFR_WDATA[7:5];
        end
        `CIT_ADDR_TAG3: begin
          if (ext_sel) tag_q[OBJ_SEL].id[12:5] <= SFR_WDATA;
        end
        `CIT_ADDR_TAG4: begin
          if (ext_sel) begin
            tag_q[OBJ_SEL].id[4:0] <= SFR_WDATA[7:3];
            tag_q[OBJ_SEL].rb1 <= SFR_WDATA[`CIT_RB1_BIT];
          end
          tag_q[OBJ_SEL].rtr <= SFR_WDATA[`CIT_RTR_BIT];
          tag_q[OBJ_SEL].rb0 <= SFR_WDATA[`CIT_RB0_BIT];
        end
        `CIT_ADDR_MSK1: begin
          if (ext_sel) msk_q[OBJ_SEL].id[28:21] <= SFR_WDATA;
          else msk_q[OBJ_SEL].id[10:3] <= SFR_WDATA;
        end
        `CIT_ADDR_MSK2: begin
          if (ext_sel) msk_q[OBJ_SEL].id[20:13] <= SFR_WDATA;
          else msk_q[OBJ_SEL].id[2:0] <= SFR_WDATA[7:5];
        end
        `CIT_ADDR_MSK3: begin
          if (ext_sel) msk_q[OBJ_SEL].id[12:5] <= SFR_WDATA;
        end
        `CIT_ADDR_MSK4: begin
          if (ext_sel) msk_q[OBJ_SEL].id[4:0] <= SFR_WDATA[7:3];
          msk_q[OBJ_SEL].rtr <= SFR_WDATA[`CIT_RTR_BIT];
          msk_q[OBJ_SEL].extended_format_select <= SFR_WDATA[`CIT_RB0_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rst_s1 = 1'b1;
    s_d.rst_s2 = s_q.rst_s1;
    // reserved positions read as zero, one legal arbitrary value
    s_d.rdata = 8'h00;
    if (SFR_RD && SFR_SEL) begin
      case (SFR_ADDR)
        `CIT_ADDR_TAG1: s_d.rdata = ext_sel ? tsel.id[28:21] : tsel.id[10:3];
        `CIT_ADDR_TAG2: s_d.rdata = ext_sel ? tsel.id[20:13] : {tsel.id[2:0], 5'h00};
        `CIT_ADDR_TAG3: s_d.rdata = ext_sel ? tsel.id[12:5] : 8'h00;
        `CIT_ADDR_TAG4: s_d.rdata = {ext_sel ? tsel.id[4:0] : 5'h00, tsel.rtr,
                                     ext_sel ? tsel.rb1 : 1'b0, tsel.rb0};
        `CIT_ADDR_MSK1: s_d.rdata = ext_sel ? msel.id[28:21] : msel.id[10:3];
        `CIT_ADDR_MSK2: s_d.rdata = ext_sel ? msel.id[20:13] : {msel.id[2:0], 5'h00};
        `CIT_ADDR_MSK3: s_d.rdata = ext_sel ? msel.id[12:5] : 8'h00;
        `CIT_ADDR_MSK4: s_d.rdata = {ext_sel ? msel.id[4:0] : 5'h00, msel.rtr, 1'b0, msel.extended_format_select};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // transmit path ignores the mask entirely
    if (TX_OBJ < 4'(`CIT_NUM_OBJ)) begin
      s_d.tx_id = OBJ_EXT[TX_OBJ] ? tag_q[TX_OBJ].id : {18'h0_0000, tag_q[TX_OBJ].id[10:0]};
      s_d.tx_rtr = tag_q[TX_OBJ].rtr;
      s_d.tx_rb1 = OBJ_EXT[TX_OBJ] ? tag_q[TX_OBJ].rb1 : 1'b0;
      s_d.tx_rb0 = tag_q[TX_OBJ].rb0;
    end
    s_d.hit = hit_c;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign SFR_RDATA = s_q.rdata;
  assign TX_ID = s_q.tx_id;
  assign TX_RTR = s_q.tx_rtr;
  assign TX_RB1 = s_q.tx_rb1;
  assign TX_RB0 = s_q.tx_rb0;
  assign RX_HIT = s_q.hit;
endmodule

/* File: cit_top_asserts.sv */
/* port relations of the identifier tag and mask block.
   assumes binding to cit_top, one clock domain. */
module cit_top_asserts (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  input wire logic SFR_SEL,
  input wire logic [3:0] OBJ_SEL,
  input wire logic [14:0] OBJ_RX_EN,
  input wire logic [3:0] TX_OBJ,
  input wire logic [28:0] TX_ID,
  input wire logic RX_VALID,
  input wire logic [14:0] RX_HIT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // byte1 tag and mask are full-width in both layouts
  sequence s_wr_b1;
    SFR_WR && SFR_SEL && OBJ_SEL != 4'hF && (SFR_ADDR == 8'hBC || SFR_ADDR == 8'hC4);
  endsequence
  sequence s_rd_again;
    !SFR_WR && $stable(SFR_ADDR) && $stable(OBJ_SEL) ##1 SFR_RD && $stable(SFR_ADDR) && $stable(OBJ_SEL);
  endsequence
  chk_sel_map: assert property (SFR_SEL == (SFR_ADDR inside {[8'hBC:8'hBF], [8'hC4:8'hC7]}))
    else $error("select flag disagrees with address");
  chk_readback_b1: assert property (s_wr_b1 ##1 s_rd_again |=> SFR_RDATA == $past(SFR_WDATA, 3))
    else $error("byte1 read back differs from write");
  chk_rdata_idle: assert property (!SFR_RD |=> SFR_RDATA == 8'h00)
    else $error("read data not zero without read");
  chk_unmapped_rd: assert property (SFR_RD && !SFR_SEL |=> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_nosel_rd: assert property (SFR_RD && OBJ_SEL == 4'hF |=> SFR_RDATA == 8'h00)
    else $error("read with no object not zero");
  chk_tx_hold: assert property (TX_OBJ == 4'hF |=> $stable(TX_ID))
    else $error("transmit id moved with no object");
  chk_rx_idle: assert property (!RX_VALID |=> RX_HIT == 15'h0000)
    else $error("hit without valid frame");
  chk_rx_enable: assert property (RX_VALID |=> (RX_HIT & ~$past(OBJ_RX_EN)) == 15'h0000)
    else $error("hit on disabled object");
endmodule
bind cit_top cit_top_asserts u_chk (.CORE_CLK, .RST_N, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA,
  .SFR_RDATA, .SFR_SEL, .OBJ_SEL, .OBJ_RX_EN, .TX_OBJ, .TX_ID, .RX_VALID, .RX_HIT);

/* File: cit_peer.sv */
/* remote node model: presents one received frame per request.
   assumes the bench clock; lines outside a frame change every cycle. */
module cit_peer (
  input wire logic clk,
  input wire logic go,
  input wire logic [28:0] id,
  output logic rx_valid = 1'b0,
  output logic [28:0] rx_id = 29'h0000_0000,
  output logic rx_rtr = 1'b0
);
  always_ff @(posedge clk) begin
    rx_valid <= go;
    // idle lines carry no meaning, so never leave a stale frame
    rx_id <= go ? id : ~rx_id;
    rx_rtr <= go ? 1'b0 : ~rx_rtr;
  end
endmodule

/* File: cit_top_bench.sv */
/* bench: sfr writes and reads, transmit id and receive filter checks.
   assumes cit_top, cit_peer and the bound checker. */
module cit_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, go = 0, rv, rr, rtr, rb1, rb0, sel;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0] osel = 4'hF, txo = 4'hF;
  logic [28:0] gid = 29'h0000_0000, rid, txid;
  logic [14:0] hit;
  logic [7:0] ev[4] = '{8'hA5, 8'h5A, 8'hC3, 8'h3D};
  logic [7:0] sa[6] = '{8'hBC, 8'hBD, 8'hBF, 8'hC4, 8'hC5, 8'hC7};
  logic [7:0] sd[6] = '{8'h96, 8'hE0, 8'h05, 8'hF0, 8'h00, 8'h00};
  int mismatches = 0, check_count = 0;
  initial forever #12.5 clk = ~clk;
  cit_top dut (.CORE_CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata),
    .SFR_RDATA(rdata), .SFR_SEL(sel), .OBJ_SEL(osel), .OBJ_EXT(15'h0002), .OBJ_RX_EN(15'h0004), .TX_OBJ(txo),
    .TX_ID(txid), .TX_RTR(rtr), .TX_RB1(rb1), .TX_RB0(rb0), .RX_VALID(rv), .RX_ID(rid), .RX_RTR(rr),
    .RX_IDE(1'b0), .RX_HIT(hit));
  cit_peer peer (.clk(clk), .go(go), .id(gid), .rx_valid(rv), .rx_id(rid), .rx_rtr(rr));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin wr <= 1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 0;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) begin rd <= 1; addr <= a; end
    @(posedge clk) rd <= 0;
    #1 chk(rdata, e);
  endtask
  task tx(input logic [3:0] o, input logic [31:0] e, input logic [2:0] f);
    @(posedge clk) txo <= o;
    @(posedge clk) #1 chk(txid, e);
    chk({rtr, rb1, rb0}, f);
  endtask
  task rx(input logic [28:0] i, input logic e);
    @(posedge clk) begin go <= 1; gid <= i; end
    @(posedge clk) go <= 0;
    @(posedge clk) #1 chk(hit, {12'h000, e, 2'b00});
  endtask
  task print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    osel <= 4'h1;
    // extended object: every tag byte written then read back at once
    for (int i = 0; i < 4; i++) begin wrr(8'(8'hBC + i), ev[i]); rdc(8'(8'hBC + i), ev[i]); end
    @(posedge clk) osel <= 4'h2;
    for (int i = 0; i < 6; i++) begin wrr(sa[i], sd[i]); rdc(sa[i], sd[i]); end
    rdc(8'hBE, 8'h00);
    chk(sel, 1'b1);
    @(posedge clk) osel <= 4'h1;
    rdc(8'hBC, 8'hA5);
    rdc(8'hC8, 8'h00);
    chk(sel, 1'b0);
    tx(4'h1, {8'hA5, 8'h5A, 8'hC3, 5'b00111}, 3'b101);
    tx(4'h2, {18'h0_0000, 8'h96, 3'b111}, 3'b101);
    rx(29'h0000_04FD, 1'b1);
    rx(29'h0000_00B5, 1'b0);
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
